// [common/dhrc_pkg.sv]
// dhrc_pkg: offsets, bit positions and reset values for the dma control register logic
// assumes a single 100 MHz clock domain and a simple i/o register port from the pci target
// Operation
// [RULE1] set rx stopped on stop or implicit halt
// [RULE2] clear rx stopped only by rx continue
// [RULE3] bit 1 copies current tx notify flag
// [RULE4] set tx stopped on tx stop command
// [RULE5] clear tx stopped by tx continue
// [RULE6] bit 3 latched rx done until acknowledged
// [RULE7] live rx done clears at new transfer
// [RULE8] bit 4 mirrors tx done, ack clears
// [RULE9] software writes zero to reserved bits
// [RULE10] bit 8 write one stops rx
// [RULE11] bit 9 write one resumes rx
// [RULE12] bit 10 write one stops tx
// [RULE13] bit 11 write one resumes tx
// [RULE14] bit 14 high while tx transfer active
// [RULE15] software waits idle before tx reset
// [RULE16] software stops tx before polling active bit
// [RULE17] reset clears the whole register
// [RULE18] tx done sets when notify flag set
// [RULE19] rx done sets, write one acknowledges
// [RULE20] stopped engine starts no new transfer
package dhrc_pkg;
  localparam logic [7:0] DHRC_DMA_CONTROL_OFS = 8'h00;
  localparam logic [7:0] DHRC_INTERRUPT_FLAGS_OFS = 8'h48;
  localparam int DHRC_RX_STOPPED_BIT = 0;
  localparam int DHRC_TX_NOTIFY_BIT = 1;
  localparam int DHRC_TX_STOPPED_BIT = 2;
  localparam int DHRC_RX_DONE_BIT = 3;
  localparam int DHRC_TX_DONE_BIT = 4;
  localparam int DHRC_RX_STOP_CMD_BIT = 8;
  localparam int DHRC_RX_CONT_CMD_BIT = 9;
  localparam int DHRC_TX_STOP_CMD_BIT = 10;
  localparam int DHRC_TX_CONT_CMD_BIT = 11;
  localparam int DHRC_TX_ACTIVE_BIT = 14;
  localparam int DHRC_INT_TX_DONE_BIT = 9;
  localparam int DHRC_INT_RX_DONE_BIT = 10;
  localparam logic [31:0] DHRC_CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] DHRC_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] DHRC_FLAGS_ACK_MASK = 16'h0600;
endpackage

// [design/dhrc_engine_gate.sv]
// dhrc_engine_gate: halted state of one dma engine plus its start gate
// assumes stop and continue arrive as one-cycle pulses on ref_clk
`timescale 1ns/1ps
module dhrc_engine_gate (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stop_cmd,
  input wire logic implicit_stop,
  input wire logic continue_cmd,
  input wire logic start_req,
  output logic stopped,
  output logic start_ok
);
  logic next_stopped;

  // a stop in the same cycle as a continue wins, so a halt is never lost
  always_comb begin
    next_stopped = stopped;
    if (continue_cmd) begin
      next_stopped = 1'b0;
    end
    if (stop_cmd || implicit_stop) begin
      next_stopped = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopped <= 1'b0;
    end else begin
      stopped <= next_stopped;
    end
  end

  // a stop pulse blocks the start at once, not one cycle later
  assign start_ok = start_req && !stopped && !stop_cmd && !implicit_stop; // [RULE20]
endmodule

// [design/dhrc_dma_control.sv]
// dhrc_dma_control: dma control register with halt/resume commands and completion status
// assumes the pci target decodes i/o accesses into one-cycle read/write strobes
`timescale 1ns/1ps
module dhrc_dma_control (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  output logic [31:0] reg_rdata,
  input wire logic rx_start_req,
  input wire logic rx_fetch_done_seen,
  input wire logic rx_transfer_begin,
  input wire logic rx_transfer_end,
  input wire logic tx_start_req,
  input wire logic tx_start_fire,
  input wire logic tx_done_notify_flag,
  input wire logic tx_transfer_end,
  input wire logic tx_busy,
  output logic rx_start_ok,
  output logic tx_start_ok,
  output logic rx_engine_stopped,
  output logic tx_engine_stopped,
  output logic rx_engine_live_status,
  output logic [15:0] interrupt_flags,
  output logic tx_transfer_active
);
  logic ctl_hit;
  logic flags_hit;
  logic rx_stop_cmd;
  logic rx_continue_cmd;
  logic tx_stop_cmd;
  logic tx_continue_cmd;
  logic tx_completion_request_copy;
  logic next_tx_copy;
  logic next_rx_live;
  logic next_tx_active;
  logic [15:0] next_flags;
  logic [31:0] next_rdata;
  logic [31:0] ctl_view;

  assign ctl_hit = reg_addr == dhrc_pkg::DHRC_DMA_CONTROL_OFS;
  assign flags_hit = reg_addr == dhrc_pkg::DHRC_INTERRUPT_FLAGS_OFS;

  // command bits are pulses from a written one; a written zero does nothing
  assign rx_stop_cmd = reg_wr && ctl_hit && reg_be[1] &&
    reg_wdata[dhrc_pkg::DHRC_RX_STOP_CMD_BIT]; // [RULE10]
  assign rx_continue_cmd = reg_wr && ctl_hit && reg_be[1] &&
    reg_wdata[dhrc_pkg::DHRC_RX_CONT_CMD_BIT]; // [RULE11]
  assign tx_stop_cmd = reg_wr && ctl_hit && reg_be[1] &&
    reg_wdata[dhrc_pkg::DHRC_TX_STOP_CMD_BIT]; // [RULE12]
  assign tx_continue_cmd = reg_wr && ctl_hit && reg_be[1] &&
    reg_wdata[dhrc_pkg::DHRC_TX_CONT_CMD_BIT]; // [RULE13]

  // implicit halt: fetched descriptor already shows completion
  dhrc_engine_gate u_rx_gate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .stop_cmd(rx_stop_cmd), // [RULE1]
    .implicit_stop(rx_fetch_done_seen), // [RULE1]
    .continue_cmd(rx_continue_cmd), // [RULE2]
    .start_req(rx_start_req),
    .stopped(rx_engine_stopped),
    .start_ok(rx_start_ok)
  );

  dhrc_engine_gate u_tx_gate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .stop_cmd(tx_stop_cmd), // [RULE4]
    .implicit_stop(1'b0),
    .continue_cmd(tx_continue_cmd), // [RULE5]
    .start_req(tx_start_req),
    .stopped(tx_engine_stopped),
    .start_ok(tx_start_ok)
  );

  always_comb begin
    next_tx_copy = tx_completion_request_copy;
    if (tx_start_fire) begin
      next_tx_copy = tx_done_notify_flag; // [RULE3]
    end
    next_rx_live = rx_engine_live_status;
    if (rx_transfer_end) begin
      next_rx_live = 1'b1;
    end
    // a new frame wipes the live indication, unlike the latched copy
    if (rx_transfer_begin) begin
      next_rx_live = 1'b0; // [RULE7]
    end
    next_tx_active = tx_busy; // [RULE14]
    next_flags = interrupt_flags;
    // write-one acknowledge; a completion in the same cycle wins
    if (reg_wr && flags_hit && reg_be[1]) begin
      next_flags = interrupt_flags & ~(reg_wdata[15:0] & dhrc_pkg::DHRC_FLAGS_ACK_MASK); // [RULE19]
    end
    if (tx_transfer_end && tx_completion_request_copy) begin
      next_flags[dhrc_pkg::DHRC_INT_TX_DONE_BIT] = 1'b1; // [RULE18]
    end
    if (rx_transfer_end) begin
      next_flags[dhrc_pkg::DHRC_INT_RX_DONE_BIT] = 1'b1; // [RULE19]
    end
  end

  always_comb begin
    ctl_view = 32'h0000_0000;
    ctl_view[dhrc_pkg::DHRC_RX_STOPPED_BIT] = rx_engine_stopped;
    ctl_view[dhrc_pkg::DHRC_TX_NOTIFY_BIT] = tx_completion_request_copy;
    ctl_view[dhrc_pkg::DHRC_TX_STOPPED_BIT] = tx_engine_stopped;
    ctl_view[dhrc_pkg::DHRC_RX_DONE_BIT] = interrupt_flags[dhrc_pkg::DHRC_INT_RX_DONE_BIT]; // [RULE6]
    ctl_view[dhrc_pkg::DHRC_TX_DONE_BIT] = interrupt_flags[dhrc_pkg::DHRC_INT_TX_DONE_BIT]; // [RULE8]
    ctl_view[dhrc_pkg::DHRC_TX_ACTIVE_BIT] = tx_transfer_active;
    // command bits self-clear, so they always read back zero
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (ctl_hit) begin
        next_rdata = ctl_view;
      end else if (flags_hit) begin
        next_rdata = {16'h0000, interrupt_flags};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_completion_request_copy <= 1'b0; // [RULE17]
      rx_engine_live_status <= 1'b0;
      tx_transfer_active <= 1'b0;
      interrupt_flags <= dhrc_pkg::DHRC_FLAGS_RESET;
      reg_rdata <= dhrc_pkg::DHRC_CONTROL_RESET;
    end else begin
      tx_completion_request_copy <= next_tx_copy;
      rx_engine_live_status <= next_rx_live;
      tx_transfer_active <= next_tx_active;
      interrupt_flags <= next_flags;
      reg_rdata <= next_rdata;
    end
  end
endmodule

// [tb/dhrc_monitor.sv]
// dhrc_monitor: port assertions for the dma control register block
// assumes reset is held low for the first edges
`timescale 1ns/1ps
module dhrc_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic rx_fetch_done_seen,
  input wire logic rx_transfer_begin,
  input wire logic rx_transfer_end,
  input wire logic tx_transfer_end,
  input wire logic tx_busy,
  input wire logic rx_start_ok,
  input wire logic tx_start_ok,
  input wire logic rx_engine_stopped,
  input wire logic tx_engine_stopped,
  input wire logic rx_engine_live_status,
  input wire logic [15:0] interrupt_flags,
  input wire logic tx_transfer_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire ctl = reg_wr && reg_addr == 8'h00 && reg_be[1];
  wire ack = reg_wr && reg_addr == 8'h48 && reg_be[1];
  a_rx_stop_sets: assert property (ctl && reg_wdata[8] |=> rx_engine_stopped)
    else $error("rx stop lost");
  a_rx_implicit_stop: assert property (rx_fetch_done_seen |=> rx_engine_stopped)
    else $error("implicit stop lost");
  a_rx_clear_cause: assert property ($fell(rx_engine_stopped) |-> $past(ctl && reg_wdata[9]))
    else $error("rx stop cleared without resume");
  a_rx_resume_clears: assert property (ctl && reg_wdata[9] && !reg_wdata[8] && !rx_fetch_done_seen
    |=> !rx_engine_stopped) else $error("rx resume lost");
  a_tx_stop_sets: assert property (ctl && reg_wdata[10] |=> tx_engine_stopped)
    else $error("tx stop lost");
  a_tx_clear_cause: assert property ($fell(tx_engine_stopped) |-> $past(ctl && reg_wdata[11]))
    else $error("tx stop cleared without resume");
  a_stopped_no_start: assert property (!(rx_engine_stopped && rx_start_ok) && !(tx_engine_stopped && tx_start_ok))
    else $error("start granted while stopped");
  a_active_follows_busy: assert property (1'b1 |=> tx_transfer_active == $past(tx_busy))
    else $error("active bit wrong");
  a_rx_done_latch: assert property (rx_transfer_end |=> interrupt_flags[10] && rx_engine_live_status)
    else $error("rx done not set");
  a_tx_ack_clears: assert property (ack && reg_wdata[9] && !tx_transfer_end |=> !interrupt_flags[9])
    else $error("tx done not cleared");
  a_live_begin_clears: assert property (rx_transfer_begin && !rx_transfer_end |=> !rx_engine_live_status)
    else $error("live rx done not cleared");
  c_rx_stop: cover property (ctl && reg_wdata[8]);
  c_tx_resume: cover property ($fell(tx_engine_stopped));
  c_rx_done: cover property (rx_transfer_end);
endmodule
bind dhrc_dma_control dhrc_monitor i_dhrc_monitor (.*);

// [tb/dhrc_host_model.sv]
// dhrc_host_model: host driver side issuing i/o register accesses
// assumes one access at a time with one-cycle strobes
`timescale 1ns/1ps
module dhrc_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [31:0] reg_wdata = 32'h0000_0000,
  output logic [3:0] reg_be = 4'hF,
  input wire logic [31:0] reg_rdata
);
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d & 32'hFFFF_CF1F;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~reg_wdata; // stale data must not look valid
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
endmodule

// [tb/tb_top.sv]
// tb_top: directed tests of halt, resume and completion status
// assumes engines are stood in by pulses from this bench
`timescale 1ns/1ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, v); end end
module tb_top;
  logic ref_clk = 0, rst_n = 0, rx_start_req = 1, tx_start_req = 1;
  logic tx_done_notify_flag = 0, tx_busy = 0;
  logic [4:0] ev = 5'h00;
  int failures = 0, total_checks = 0;
  wire rx_fetch_done_seen = ev[0], rx_transfer_begin = ev[1], rx_transfer_end = ev[2];
  wire tx_start_fire = ev[3], tx_transfer_end = ev[4];
  wire [7:0] reg_addr;
  wire reg_wr, reg_rd, rx_start_ok, tx_start_ok, rx_engine_stopped, tx_engine_stopped;
  wire rx_engine_live_status, tx_transfer_active;
  wire [31:0] reg_wdata, reg_rdata;
  wire [3:0] reg_be;
  wire [15:0] interrupt_flags;
  dhrc_dma_control i_dhrc_dma_control (.*);
  dhrc_host_model i_dhrc_host_model (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_dhrc_host_model.rd(a, q);
    `CHK("rdata", e, q)
  endtask
  task wc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    i_dhrc_host_model.wr(a, d);
    rc(8'h00, e);
  endtask
  task pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(8'h00, 32'h0);
    rc(8'h48, 32'h0);
    rc(8'h10, 32'h0);
    wc(8'h00, 32'h0, 32'h0);
    wc(8'h00, 32'h100, 32'h1);
    `CHK("rx_stopped", 1'b1, rx_engine_stopped)
    `CHK("rx_start_ok", 1'b0, rx_start_ok)
    wc(8'h00, 32'h800, 32'h1);
    wc(8'h00, 32'h200, 32'h0);
    `CHK("rx_start_ok", 1'b1, rx_start_ok)
    pulse(0);
    wc(8'h00, 32'h300, 32'h1);
    wc(8'h00, 32'h200, 32'h0);
    wc(8'h00, 32'h400, 32'h4);
    `CHK("tx_start_ok", 1'b0, tx_start_ok)
    wc(8'h00, 32'hC00, 32'h4);
    wc(8'h00, 32'h800, 32'h0);
    `CHK("tx_stopped", 1'b0, tx_engine_stopped)
    `CHK("tx_start_ok", 1'b1, tx_start_ok)
    @(posedge ref_clk);
    tx_done_notify_flag <= 1'b1;
    tx_busy <= 1'b1;
    pulse(3);
    rc(8'h00, 32'h4002);
    wc(8'h00, 32'h400, 32'h4006);
    @(posedge ref_clk);
    tx_busy <= 1'b0;
    pulse(4);
    rc(8'h00, 32'h16);
    rc(8'h48, 32'h200);
    `CHK("flags", 16'h0200, interrupt_flags)
    `CHK("tx_active", 1'b0, tx_transfer_active)
    wc(8'h48, 32'h200, 32'h6);
    wc(8'h00, 32'h800, 32'h2);
    pulse(1);
    pulse(2);
    `CHK("rx_live", 1'b1, rx_engine_live_status)
    rc(8'h48, 32'h400);
    pulse(1);
    `CHK("rx_live", 1'b0, rx_engine_live_status)
    rc(8'h00, 32'hA);
    wc(8'h48, 32'h400, 32'h2);
    end_of_test;
  end
endmodule
